//--- include/clock_source_select_defines.svh
// Register map, field layout, encodings and counts of the clock source select
`ifndef CLOCK_SOURCE_SELECT_DEFINES_SVH
`define CLOCK_SOURCE_SELECT_DEFINES_SVH

`define CSS_ADDR_W 4
`define CSS_OFS_REQUEST 4'h0
`define CSS_OFS_STATUS 4'h1
`define CSS_OFS_FAST_FREQ 4'h2
`define CSS_OFS_READY 4'h3

`define CSS_SRC_MSB 6
`define CSS_SRC_LSB 4
`define CSS_DIV_MSB 3
`define CSS_DIV_LSB 0

// Source selection codes
`define CSS_SRC_FAST_32M 3'h0
`define CSS_SRC_RSVD_1 3'h1
`define CSS_SRC_RSVD_2 3'h2
`define CSS_SRC_RSVD_3 3'h3
`define CSS_SRC_EXTERNAL 3'h4
`define CSS_SRC_SLOW_31K 3'h5
`define CSS_SRC_FAST_4M 3'h6
`define CSS_SRC_FAST_SEL 3'h7

`define CSS_DIV_RST_4M 4'h2
`define CSS_DIV_RST_OTHER 4'h0

// External mode fuse codes
`define CSS_EXT_EC_HIGH 3'h0
`define CSS_EXT_EC_MED 3'h1
`define CSS_EXT_EC_LOW 3'h2
`define CSS_EXT_XTAL_LOW 3'h3
`define CSS_EXT_XTAL_MED 3'h4
`define CSS_EXT_XTAL_HIGH 3'h5

// Amplifier gain drive
`define CSS_GAIN_OFF 2'h0
`define CSS_GAIN_LOW 2'h1
`define CSS_GAIN_MED 2'h2
`define CSS_GAIN_HIGH 2'h3

// Fast internal oscillator frequency codes, 1 to 32 MHz
`define CSS_FREQ_1M 3'h0
`define CSS_FREQ_2M 3'h1
`define CSS_FREQ_4M 3'h2
`define CSS_FREQ_8M 3'h3
`define CSS_FREQ_12M 3'h4
`define CSS_FREQ_16M 3'h5
`define CSS_FREQ_32M 3'h6
`define CSS_FREQ_RST 3'h2

`define CSS_SLOW_FREQ_KHZ 31
`define CSS_WATCH_XTAL_HZ 32768

// External clock limits per power setting, in kHz
`define CSS_EC_HIGH_MAX_KHZ 32000
`define CSS_EC_MED_MAX_KHZ 8000
`define CSS_EC_LOW_MAX_KHZ 500

// Start-up timer length in resonator oscillations
`define CSS_OST_W 11
`define CSS_OST_COUNT 11'h400

`endif

//--- include/clock_source_select_pkg.sv
// Types shared by the clock source select logic
package clock_source_select_pkg;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT_READY,
    SW_COMMIT
  } switch_state_t;

  typedef enum logic [1:0] {
    OST_IDLE,
    OST_COUNTING,
    OST_STABLE
  } ost_state_t;

endpackage

//--- src/clock_source_select.sv
// Clock source selection, start-up timing and source status registers
`include "clock_source_select_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module clock_source_select (
  input wire logic mclk_i,                // System clock, 10 MHz
  input wire logic sys_rst_i,             // Synchronous reset, active high
  input wire logic [`CSS_ADDR_W-1:0] reg_addr_i, // Register address
  input wire logic [7:0] reg_wdata_i,     // Register write data
  input wire logic reg_wr_i,              // Write strobe
  input wire logic reg_rd_i,              // Read strobe
  output logic [7:0] reg_rdata_o,         // Read data, cycle after strobe
  input wire logic [2:0] reset_source_fuse_i, // Reset source fuse
  input wire logic switch_allow_fuse_i,   // Clock switching allowed
  input wire logic [2:0] ext_mode_fuse_i, // External mode fuse
  input wire logic por_event_i,           // Power-on reset event pulse
  input wire logic brownout_reset_i,      // Brown-out reset event pulse
  input wire logic wake_event_i,          // Wake from sleep pulse
  input wire logic resonator_in_pin_i,    // Resonator input pin level
  input wire logic fast_osc_ready_i,      // Fast internal osc stable
  input wire logic slow_osc_ready_i,      // Slow internal osc stable
  output logic [2:0] sys_source_sel_o,    // Source driving system clock
  output logic [3:0] sys_divider_o,       // Postscaler on system clock
  output logic fast_osc_en_o,             // Fast internal osc enable
  output logic [2:0] fast_osc_freq_o,     // Fast internal osc frequency
  output logic slow_osc_en_o,             // Slow internal osc enable
  output logic [1:0] amp_gain_o,          // Crystal amplifier gain
  output logic resonator_out_free_o,      // Output pin free for I/O
  output logic ext_ready_o,               // External source usable
  output logic code_run_o,                // User code may execute
  output logic switch_busy_o              // Source switch pending
);

  function automatic logic src_reserved(input logic [2:0] code);
    src_reserved = (code == `CSS_SRC_RSVD_1) ||
                   (code == `CSS_SRC_RSVD_2) ||
                   (code == `CSS_SRC_RSVD_3);
  endfunction

  function automatic logic [3:0] div_reset(input logic [2:0] code);
    if (code == `CSS_SRC_FAST_4M) begin
      div_reset = `CSS_DIV_RST_4M;
    end else begin
      div_reset = `CSS_DIV_RST_OTHER;
    end
  endfunction

  function automatic logic ext_is_crystal(input logic [2:0] mode);
    ext_is_crystal = (mode == `CSS_EXT_XTAL_LOW) ||
                     (mode == `CSS_EXT_XTAL_MED) ||
                     (mode == `CSS_EXT_XTAL_HIGH);
  endfunction

  function automatic logic fast_src(input logic [2:0] code);
    fast_src = (code == `CSS_SRC_FAST_32M) ||
               (code == `CSS_SRC_FAST_4M) ||
               (code == `CSS_SRC_FAST_SEL);
  endfunction

  // Synchronisers for pin and oscillator status inputs
  logic res_s1_r;
  logic res_s2_r;
  logic res_s3_r;
  logic fast_s1_r;
  logic fast_s2_r;
  logic slow_s1_r;
  logic slow_s2_r;

  logic [2:0] req_src_r;
  logic [3:0] req_div_r;
  logic [2:0] act_src_r;
  logic [3:0] act_div_r;
  logic [2:0] freq_r;
  logic [2:0] ext_mode_r;
  logic ext_ready_r;
  logic code_run_r;
  logic [`CSS_OST_W-1:0] ost_cnt_r;
  clock_source_select_pkg::ost_state_t ost_state_r;
  clock_source_select_pkg::switch_state_t sw_state_r;

  logic res_rise;
  logic ost_start;
  logic req_wr;
  logic req_wr_ok;
  logic target_ready;
  logic act_ready;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      res_s1_r <= 1'b0;
      res_s2_r <= 1'b0;
      res_s3_r <= 1'b0;
      fast_s1_r <= 1'b0;
      fast_s2_r <= 1'b0;
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
    end else begin
      res_s1_r <= resonator_in_pin_i;
      res_s2_r <= res_s1_r;
      res_s3_r <= res_s2_r;
      fast_s1_r <= fast_osc_ready_i;
      fast_s2_r <= fast_s1_r;
      slow_s1_r <= slow_osc_ready_i;
      slow_s2_r <= slow_s1_r;
    end
  end

  // One oscillation counted per rising edge at the input pin
  assign res_rise = res_s2_r & ~res_s3_r;
  assign ost_start = por_event_i | brownout_reset_i | wake_event_i;

  assign req_wr = reg_wr_i && (reg_addr_i == `CSS_OFS_REQUEST);
  assign req_wr_ok = req_wr && switch_allow_fuse_i &&
    !src_reserved(reg_wdata_i[`CSS_SRC_MSB:`CSS_SRC_LSB]);

  // Fuse straps taken at reset; synchronous reset so the port is sampled
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ext_mode_r <= ext_mode_fuse_i;
    end
  end

  // Crystal start-up timer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ost_state_r <= clock_source_select_pkg::OST_IDLE;
      ost_cnt_r <= '0;
      ext_ready_r <= 1'b0;
    end else if (!ext_is_crystal(ext_mode_r)) begin
      ost_state_r <= clock_source_select_pkg::OST_STABLE;
      ost_cnt_r <= '0;
      ext_ready_r <= 1'b1;
    end else if (ost_start) begin
      // An event pulse wins over a pin rise in the same cycle
      ost_state_r <= clock_source_select_pkg::OST_COUNTING;
      ost_cnt_r <= '0;
      ext_ready_r <= 1'b0;
    end else begin
      case (ost_state_r)
        clock_source_select_pkg::OST_IDLE: begin
          ost_state_r <= clock_source_select_pkg::OST_COUNTING;
          ost_cnt_r <= '0;
        end
        clock_source_select_pkg::OST_COUNTING: begin
          // No timeout: a silent resonator simply holds the count
          if (res_rise) begin
            if (ost_cnt_r == `CSS_OST_COUNT - 11'h001) begin
              ost_state_r <= clock_source_select_pkg::OST_STABLE;
              ext_ready_r <= 1'b1;
              ost_cnt_r <= '0;
            end else begin
              ost_cnt_r <= ost_cnt_r + 11'h001;
            end
          end
        end
        clock_source_select_pkg::OST_STABLE: begin
          ext_ready_r <= 1'b1;
        end
        default: begin
          ost_state_r <= clock_source_select_pkg::OST_IDLE;
          ext_ready_r <= 1'b0;
        end
      endcase
    end
  end

  // Request register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      req_src_r <= reset_source_fuse_i;
      req_div_r <= div_reset(reset_source_fuse_i);
    end else if (req_wr_ok) begin
      req_src_r <= reg_wdata_i[`CSS_SRC_MSB:`CSS_SRC_LSB];
      req_div_r <= reg_wdata_i[`CSS_DIV_MSB:`CSS_DIV_LSB];
    end
  end

  // Fast oscillator frequency select
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      freq_r <= `CSS_FREQ_RST;
    end else if (reg_wr_i && (reg_addr_i == `CSS_OFS_FAST_FREQ) &&
                 (reg_wdata_i[2:0] <= `CSS_FREQ_32M)) begin
      freq_r <= reg_wdata_i[2:0];
    end
  end

  always_comb begin
    case (req_src_r)
      `CSS_SRC_FAST_32M: target_ready = fast_s2_r;
      `CSS_SRC_FAST_4M: target_ready = fast_s2_r;
      `CSS_SRC_FAST_SEL: target_ready = fast_s2_r;
      `CSS_SRC_SLOW_31K: target_ready = slow_s2_r;
      `CSS_SRC_EXTERNAL: target_ready = ext_ready_r;
      default: target_ready = 1'b0;
    endcase
  end

  always_comb begin
    case (act_src_r)
      `CSS_SRC_FAST_32M: act_ready = fast_s2_r;
      `CSS_SRC_FAST_4M: act_ready = fast_s2_r;
      `CSS_SRC_FAST_SEL: act_ready = fast_s2_r;
      `CSS_SRC_SLOW_31K: act_ready = slow_s2_r;
      `CSS_SRC_EXTERNAL: act_ready = ext_ready_r;
      default: act_ready = 1'b0;
    endcase
  end

  // Active source follows the request once the target is ready
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sw_state_r <= clock_source_select_pkg::SW_IDLE;
      act_src_r <= reset_source_fuse_i;
      act_div_r <= div_reset(reset_source_fuse_i);
    end else begin
      case (sw_state_r)
        clock_source_select_pkg::SW_IDLE: begin
          if (req_src_r != act_src_r || req_div_r != act_div_r) begin
            sw_state_r <= clock_source_select_pkg::SW_WAIT_READY;
          end
        end
        clock_source_select_pkg::SW_WAIT_READY: begin
          if (target_ready) begin
            sw_state_r <= clock_source_select_pkg::SW_COMMIT;
          end
        end
        clock_source_select_pkg::SW_COMMIT: begin
          // Readiness checked again: the request may move while waiting
          if (target_ready) begin
            act_src_r <= req_src_r;
            act_div_r <= req_div_r;
            sw_state_r <= clock_source_select_pkg::SW_IDLE;
          end else begin
            sw_state_r <= clock_source_select_pkg::SW_WAIT_READY;
          end
        end
        default: begin
          sw_state_r <= clock_source_select_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // Code execution starts once the active source is running
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || ost_start) begin
      code_run_r <= 1'b0;
    end else if (act_ready) begin
      code_run_r <= 1'b1;
    end
  end

  // Read port
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `CSS_OFS_REQUEST: reg_rdata_o <= {1'b0, req_src_r, req_div_r};
        `CSS_OFS_STATUS: reg_rdata_o <= {1'b0, act_src_r, act_div_r};
        `CSS_OFS_FAST_FREQ: reg_rdata_o <= {5'h00, freq_r};
        `CSS_OFS_READY: reg_rdata_o <= {4'h0, code_run_r, ext_ready_r,
                                         slow_s2_r, fast_s2_r};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Clock tree controls
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      // Fuse-selected source drives the tree from the first reset edge
      sys_source_sel_o <= reset_source_fuse_i;
      sys_divider_o <= div_reset(reset_source_fuse_i);
      fast_osc_en_o <= 1'b0;
      fast_osc_freq_o <= `CSS_FREQ_RST;
      slow_osc_en_o <= 1'b0;
      ext_ready_o <= 1'b0;
      code_run_o <= 1'b0;
      switch_busy_o <= 1'b0;
    end else begin
      sys_source_sel_o <= act_src_r;
      sys_divider_o <= act_div_r;
      fast_osc_en_o <= fast_src(act_src_r) || fast_src(req_src_r);
      case (act_src_r)
        `CSS_SRC_FAST_32M: fast_osc_freq_o <= `CSS_FREQ_32M;
        `CSS_SRC_FAST_4M: fast_osc_freq_o <= `CSS_FREQ_4M;
        default: fast_osc_freq_o <= freq_r;
      endcase
      slow_osc_en_o <= (act_src_r == `CSS_SRC_SLOW_31K) ||
                       (req_src_r == `CSS_SRC_SLOW_31K);
      ext_ready_o <= ext_ready_r;
      code_run_o <= code_run_r;
      switch_busy_o <= (sw_state_r != clock_source_select_pkg::SW_IDLE);
    end
  end

  // Amplifier gain and output pin use
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      amp_gain_o <= `CSS_GAIN_OFF;
      resonator_out_free_o <= 1'b1;
    end else begin
      case (ext_mode_r)
        `CSS_EXT_XTAL_LOW: amp_gain_o <= `CSS_GAIN_LOW;
        `CSS_EXT_XTAL_MED: amp_gain_o <= `CSS_GAIN_MED;
        `CSS_EXT_XTAL_HIGH: amp_gain_o <= `CSS_GAIN_HIGH;
        default: amp_gain_o <= `CSS_GAIN_OFF;
      endcase
      resonator_out_free_o <= !ext_is_crystal(ext_mode_r);
    end
  end

endmodule

`default_nettype wire

//--- verif/clock_source_select_assertions.sv
// Port-level checks for the clock source select
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_select_defines.svh"

module clock_source_select_checker (
  input wire logic mclk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic [`CSS_ADDR_W-1:0] reg_addr_i, // Address
  input wire logic reg_rd_i, // Read strobe
  input wire logic [7:0] reg_rdata_o, // Read data
  input wire logic [2:0] ext_mode_fuse_i, // External mode fuse
  input wire logic por_event_i, // Power-on event
  input wire logic brownout_reset_i, // Brown-out event
  input wire logic wake_event_i, // Wake event
  input wire logic resonator_in_pin_i, // Resonator pin
  input wire logic [2:0] sys_source_sel_o, // Active source
  input wire logic [3:0] sys_divider_o, // Active divider
  input wire logic switch_busy_o, // Switch pending
  input wire logic [1:0] amp_gain_o, // Amplifier gain
  input wire logic resonator_out_free_o, // Output pin free
  input wire logic ext_ready_o, // External source usable
  input wire logic code_run_o // Code may run
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic evt;
  logic [2:0] pin_s;
  logic [11:0] rise_cnt;
  assign evt = por_event_i | brownout_reset_i | wake_event_i;
  always_ff @(posedge mclk_i) begin
    pin_s <= {pin_s[1:0], resonator_in_pin_i};
  end
  // Synchronised pin rises since the last restart
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || evt) begin
      rise_cnt <= 12'h000;
    end else if (pin_s[1] && !pin_s[2] && rise_cnt != 12'hFFF) begin
      rise_cnt <= rise_cnt + 12'h001;
    end
  end
  rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read slot");
  bit7_zero_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) < 4'h2 |-> !reg_rdata_o[7])
    else $error("bit 7 reads one");
  switch_gate_a: assert property (
    !$past(sys_rst_i) && !$past(sys_rst_i, 2) &&
    (!$stable(sys_source_sel_o) || !$stable(sys_divider_o))
    |-> $past(switch_busy_o)) else $error("source changed unasked");
  gain_fuse_a: assert property (
    ext_mode_fuse_i >= 3'h3 && !$past(sys_rst_i)
    |-> {1'b0, amp_gain_o} == ext_mode_fuse_i - 3'h2)
    else $error("gain does not match crystal mode");
  pin_free_a: assert property (
    !$past(sys_rst_i) |-> resonator_out_free_o == (ext_mode_fuse_i < 3'h3))
    else $error("output pin freeing wrong");
  ost_restart_a: assert property (
    evt && ext_mode_fuse_i >= 3'h3 |-> ##[1:2] !ext_ready_o)
    else $error("start-up not restarted");
  ost_count_a: assert property (
    $rose(ext_ready_o) && ext_mode_fuse_i >= 3'h3 |-> rise_cnt >= 12'h400)
    else $error("ready before 1024 rises");
  ec_bypass_a: assert property (
    $fell(sys_rst_i) && ext_mode_fuse_i < 3'h3 |-> ##[0:2] ext_ready_o)
    else $error("external clock delayed");
  run_drop_a: assert property (evt |-> ##[1:2] !code_run_o)
    else $error("code run kept after event");
  cover property ($rose(ext_ready_o));
  cover property ($fell(switch_busy_o));
  cover property (evt && ext_ready_o);
endmodule

bind clock_source_select clock_source_select_checker u_chk (.mclk_i,
  .sys_rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .ext_mode_fuse_i,
  .por_event_i, .brownout_reset_i, .wake_event_i, .resonator_in_pin_i,
  .sys_source_sel_o, .sys_divider_o, .switch_busy_o, .amp_gain_o,
  .resonator_out_free_o, .ext_ready_o, .code_run_o);

`default_nettype wire

//--- verif/clock_source_select_bench.sv
// Register, switch and start-up tests for the clock source select
`timescale 1ns/1ps
`default_nettype none

module clock_source_select_bench;
  logic mclk_i, sys_rst_i, reg_wr_i, reg_rd_i, switch_allow_fuse_i;
  logic por_event_i, brownout_reset_i, wake_event_i, resonator_in_pin_i;
  logic fast_osc_ready_i, slow_osc_ready_i, fast_osc_en_o, slow_osc_en_o;
  logic resonator_out_free_o, ext_ready_o, code_run_o, switch_busy_o;
  logic [3:0] reg_addr_i, sys_divider_o;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [2:0] reset_source_fuse_i, ext_mode_fuse_i, sys_source_sel_o;
  logic [2:0] fast_osc_freq_o;
  logic [1:0] amp_gain_o;
  int num_errors = 0;
  int cmp_count = 0;

  clock_source_select u_dut (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reset_source_fuse_i,
    .switch_allow_fuse_i, .ext_mode_fuse_i, .por_event_i, .brownout_reset_i,
    .wake_event_i, .resonator_in_pin_i, .fast_osc_ready_i, .slow_osc_ready_i,
    .sys_source_sel_o, .sys_divider_o, .fast_osc_en_o, .fast_osc_freq_o,
    .slow_osc_en_o, .amp_gain_o, .resonator_out_free_o, .ext_ready_o,
    .code_run_o, .switch_busy_o);
  crystal_source_model u_xtal (.gain_i(amp_gain_o),
    .pin_o(resonator_in_pin_i));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask

  task automatic do_rst(input logic [2:0] src, input logic allow,
    input logic [2:0] mode);
    @(posedge mclk_i);
    reset_source_fuse_i <= src;
    switch_allow_fuse_i <= allow;
    ext_mode_fuse_i <= mode;
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask

  // Pulse lands away from a pin rise
  task automatic ev(input logic [2:0] k);
    @(negedge resonator_in_pin_i);
    @(posedge mclk_i);
    {por_event_i, brownout_reset_i, wake_event_i} <= k;
    @(posedge mclk_i);
    {por_event_i, brownout_reset_i, wake_event_i} <= 3'h0;
  endtask

  task automatic ost_wait;
    int n;
    repeat (4000) @(posedge mclk_i);
    #1;
    chk({6'h00, code_run_o, ext_ready_o}, 8'h00);
    n = 0;
    while (ext_ready_o !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk({7'h00, ext_ready_o}, 8'h01);
    repeat (2) @(posedge mclk_i);
    #1;
    chk({7'h00, code_run_o}, 8'h01);
  endtask

  initial begin
    repeat (50000) @(posedge mclk_i);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    sys_rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, por_event_i, brownout_reset_i, wake_event_i} = 5'h00;
    {fast_osc_ready_i, slow_osc_ready_i, switch_allow_fuse_i} = 3'h7;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reset_source_fuse_i = 3'h6;
    ext_mode_fuse_i = 3'h0;
    do_rst(3'h6, 1'b1, 3'h0);
    rc(4'h0, 8'h62);
    rc(4'h1, 8'h62);
    chk({5'h00, sys_source_sel_o}, 8'h06);
    chk({fast_osc_en_o, slow_osc_en_o, 3'h0, fast_osc_freq_o}, 8'h82);
    for (int i = 1; i < 4; i++) begin
      wr(4'h0, {1'b0, 3'(i), 4'h5});
      rc(4'h0, 8'h62);
    end
    wr(4'h0, 8'hD3);
    rc(4'h0, 8'h53);
    repeat (8) @(posedge mclk_i);
    rc(4'h1, 8'h53);
    chk({1'b0, sys_source_sel_o, sys_divider_o}, 8'h53);
    chk({fast_osc_en_o, slow_osc_en_o, 3'h0, fast_osc_freq_o}, 8'h42);
    @(posedge mclk_i) slow_osc_ready_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    wr(4'h0, 8'h50);
    repeat (8) @(posedge mclk_i);
    rc(4'h1, 8'h53);
    chk({7'h00, switch_busy_o}, 8'h01);
    @(posedge mclk_i) slow_osc_ready_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    rc(4'h1, 8'h50);
    rc(4'h3, 8'h0F);
    wr(4'h1, 8'h00);
    rc(4'h1, 8'h50);
    wr(4'h2, 8'h06);
    rc(4'h2, 8'h06);
    wr(4'h0, 8'h70);
    repeat (8) @(posedge mclk_i);
    #1;
    chk({fast_osc_en_o, slow_osc_en_o, 3'h0, fast_osc_freq_o}, 8'h86);
    wr(4'h2, 8'h07);
    rc(4'h2, 8'h06);
    rc(4'hF, 8'h00);
    $display("test registers done");
    do_rst(3'h5, 1'b0, 3'h0);
    wr(4'h0, 8'h62);
    rc(4'h0, 8'h50);
    $display("test locked request done");
    for (logic [2:0] m = 3'h0; m < 3'h3; m++) begin
      do_rst(3'h4, 1'b1, m);
      chk({7'h00, ext_ready_o}, 8'h01);
      chk({7'h00, resonator_out_free_o}, 8'h01);
      rc(4'h1, 8'h40);
    end
    $display("test external clock done");
    for (logic [2:0] m = 3'h3; m < 3'h6; m++) begin
      do_rst(3'h4, 1'b1, m);
      chk({6'h00, amp_gain_o}, {5'h00, m - 3'h2});
      chk({7'h00, resonator_out_free_o}, 8'h00);
      ost_wait();
    end
    for (int j = 0; j < 3; j++) begin
      ev(3'h4 >> j);
      ost_wait();
    end
    $display("test crystal start-up done");
    tally_and_finish();
  end
endmodule

`default_nettype wire

//--- verif/crystal_source_model.sv
// Crystal or resonator on the far side of the oscillator pins
`timescale 1ns/1ps
`default_nettype none

module crystal_source_model #(
  // About 2.5 MHz, inside the high and medium external clock limits
  parameter realtime HALF_NS = 201.373
) (
  input wire logic [1:0] gain_i, // Amplifier gain from the block
  output logic pin_o // Resonator input pin level
);
  // Oscillates only while the amplifier is driven
  always begin
    #HALF_NS;
    if (gain_i != 2'h0) begin
      pin_o = ~pin_o;
    end else begin
      pin_o = 1'b0;
    end
  end
endmodule

`default_nettype wire
